//--- design/nemm_defs.vh
`ifndef NEMM_DEFS_VH
`define NEMM_DEFS_VH

// =====================================================================
// Register byte addresses
`define NEMM_A_CTRL 8'h00
`define NEMM_A_NOISE_TH 8'h04
`define NEMM_A_MOTION 8'h08
`define NEMM_A_SMOOTH 8'h0C
`define NEMM_A_SUM0 8'h10
`define NEMM_A_CNT0 8'h14
`define NEMM_A_SUM1 8'h18
`define NEMM_A_CNT1 8'h1C
`define NEMM_A_STATUS 8'h20

// =====================================================================
// Control bits
`define NEMM_B_ILR 0
`define NEMM_B_NF 1
`define NEMM_B_STREAM 2
`define NEMM_B_FIELD2 3
`define NEMM_B_TOPFIRST 4

// =====================================================================
// Reset values
`define NEMM_R_CTRL 5'h13
`define NEMM_R_NOISE_TH 16'h0808
`define NEMM_R_MOTION 24'h100064
`define NEMM_R_SMOOTH 24'hC84020

// =====================================================================
// Block sizes (last pixel index) and estimate sentinel
`define NEMM_LAST_ILR 7'h3F
`define NEMM_LAST_NF 7'h7F
`define NEMM_EST_NONE 8'hFF
`define NEMM_SUM_W 23
`define NEMM_CNT_W 16

// =====================================================================
// Arithmetic shifts and limits
`define NEMM_GRAD_SH 3
`define NEMM_FILT_SH 3
`define NEMM_VECM_SH 5
`define NEMM_SCM_SH 4
`define NEMM_AVG_SH 8
`define NEMM_WEIGHT_ONE 256
`define NEMM_QS_MIN 3'h4
`define NEMM_QS_MAX 3'h6
`define NEMM_RS_MIN 4'h6
`define NEMM_RS_MAX 4'h8

// =====================================================================
// Motion window: 6 wide (x=-2..3), 9 high (y=-4..4)
`define NEMM_WW 6
`define NEMM_WN 54
`define NEMM_WBITS 432
`define NEMM_NF_TOP_LO (-2)
`define NEMM_NF_TOP_HI 6
`define NEMM_NF_BOT_LO (-3)
`define NEMM_NF_BOT_HI 5

`endif

//--- design/nemm_top.v
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`include "nemm_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module nemm_top (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Noise estimate pixel stream (3x3 luma, row-major)
  input wire NB_VALID,
  input wire [71:0] NB_WIN,
  input wire FRAME_END,
  // Block estimate message and frame totals to memory
  output reg [7:0] BLOCK_EST,
  output reg BLOCK_EST_VALID,
  output reg MEM_WR,
  output reg MEM_STREAM,
  output reg [22:0] MEM_SUM,
  output reg [15:0] MEM_COUNT,
  // Motion pair stream
  input wire MM_VALID,
  input wire MM_FIRST,
  input wire [3:0] MM_ROW,
  input wire [431:0] MM_CUR_RAW,
  input wire [431:0] MM_CUR_CLEAN,
  input wire [431:0] MM_REF,
  input wire [7:0] MM_SAVED,
  // Motion results
  output reg REF_IS_NEXT,
  output reg [7:0] SMOOTH_OUT,
  output reg SMOOTH_VALID,
  output reg [7:0] FINAL_OUT,
  output reg FINAL_VALID
);

  // ===================================================================
  // Register file over APB
  reg [4:0] ctrl_reg;
  reg [15:0] noise_th_reg;
  reg [23:0] motion_reg;
  reg [23:0] smooth_reg;
  reg [7:0] last_final_reg;
  reg [`NEMM_SUM_W-1:0] acc_reg [0:1];
  reg [`NEMM_CNT_W-1:0] cnt_reg [0:1];
  reg [31:0] rdata_next;
  reg addr_ok;
  wire setup_ph = PSEL & ~PENABLE;
  wire wr_take = PSEL & PENABLE & PREADY & PWRITE;

  always @* begin
    addr_ok = 1'b1;
    rdata_next = 32'h0;
    case (PADDR)
      `NEMM_A_CTRL: rdata_next = {27'h0, ctrl_reg};
      `NEMM_A_NOISE_TH: rdata_next = {16'h0, noise_th_reg};
      `NEMM_A_MOTION: rdata_next = {8'h0, motion_reg};
      `NEMM_A_SMOOTH: rdata_next = {8'h0, smooth_reg};
      `NEMM_A_SUM0: rdata_next = {9'h0, acc_reg[0]};
      `NEMM_A_CNT0: rdata_next = {16'h0, cnt_reg[0]};
      `NEMM_A_SUM1: rdata_next = {9'h0, acc_reg[1]};
      `NEMM_A_CNT1: rdata_next = {16'h0, cnt_reg[1]};
      `NEMM_A_STATUS: rdata_next = {16'h0, last_final_reg, BLOCK_EST};
      default: addr_ok = 1'b0;
    endcase
  end

  // No wait state: answer is prepared in the setup cycle
  always @(posedge CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
      ctrl_reg <= `NEMM_R_CTRL;
      noise_th_reg <= `NEMM_R_NOISE_TH;
      motion_reg <= `NEMM_R_MOTION;
      smooth_reg <= `NEMM_R_SMOOTH;
      REF_IS_NEXT <= 1'b0;
    end else begin
      PREADY <= setup_ph;
      if (setup_ph) begin
        PRDATA <= PWRITE ? 32'h0 : rdata_next;
        PSLVERR <= ~addr_ok;
      end else begin
        PSLVERR <= 1'b0;
      end
      if (wr_take) begin
        case (PADDR)
          `NEMM_A_CTRL: ctrl_reg <= PWDATA[4:0];
          `NEMM_A_NOISE_TH: noise_th_reg <= PWDATA[15:0];
          `NEMM_A_MOTION: motion_reg <= PWDATA[23:0];
          `NEMM_A_SMOOTH: smooth_reg <= PWDATA[23:0];
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
      REF_IS_NEXT <= ctrl_reg[`NEMM_B_FIELD2];
    end
  end

  wire interlace_removal_on = ctrl_reg[`NEMM_B_ILR];
  wire noise_filter_on = ctrl_reg[`NEMM_B_NF];
  wire stream_select = ctrl_reg[`NEMM_B_STREAM];
  wire top_first = ctrl_reg[`NEMM_B_TOPFIRST];
  wire [7:0] gradient_threshold = noise_th_reg[7:0];
  wire [7:0] spread_threshold = noise_th_reg[15:8];

  // ===================================================================
  // Per-pixel noise metric
  reg [7:0] npx [0:8];
  integer i, j, hz, vt, lt, le, dv, nsum, nmin, nmax;
  reg [7:0] nine_point_middle;
  reg [7:0] gradient_score;
  reg [7:0] pix_metric;
  reg pix_ok;

  always @* begin
    for (i = 0; i < 9; i = i + 1) begin
      npx[i] = NB_WIN[i*8 +: 8];
    end
    hz = npx[0] + 2 * npx[1] + npx[2] - npx[6] - 2 * npx[7] - npx[8];
    vt = npx[0] + 2 * npx[3] + npx[6] - npx[2] - 2 * npx[5] - npx[8];
    if (hz < 0) hz = -hz;
    if (vt < 0) vt = -vt;
    hz = (hz + vt) >> `NEMM_GRAD_SH;
    gradient_score = (hz > 255) ? 8'hFF : hz[7:0];
    nine_point_middle = npx[0];
    for (i = 0; i < 9; i = i + 1) begin
      lt = 0;
      le = 0;
      for (j = 0; j < 9; j = j + 1) begin
        if (npx[j] < npx[i]) lt = lt + 1;
        if (npx[j] <= npx[i]) le = le + 1;
      end
      if (lt <= 4 && le >= 5) nine_point_middle = npx[i];
    end
    nsum = 0;
    nmin = 255;
    nmax = 0;
    for (i = 0; i < 9; i = i + 1) begin
      dv = npx[i] - nine_point_middle;
      if (dv < 0) dv = -dv;
      nsum = nsum + dv;
      if (dv < nmin) nmin = dv;
      if (dv > nmax) nmax = dv;
    end
    pix_metric = (nsum > 255) ? 8'hFF : nsum[7:0];
    pix_ok = (gradient_score < gradient_threshold) &&
             ((nmax - nmin) < spread_threshold);
  end

  // ===================================================================
  // Block minimum and frame accumulation
  reg [6:0] pix_cnt_reg;
  reg [7:0] blk_min_reg;
  wire [7:0] blk_cand = (pix_ok && pix_metric < blk_min_reg) ? pix_metric : blk_min_reg;
  wire [6:0] blk_last = interlace_removal_on ? `NEMM_LAST_ILR : `NEMM_LAST_NF;
  wire blk_done = NB_VALID && (pix_cnt_reg == blk_last);
  wire blk_add = blk_done && (blk_cand != `NEMM_EST_NONE);

  always @(posedge CLK) begin
    if (!RST_N) begin
      pix_cnt_reg <= 7'h00;
      blk_min_reg <= `NEMM_EST_NONE;
      BLOCK_EST <= `NEMM_EST_NONE;
      BLOCK_EST_VALID <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_STREAM <= 1'b0;
      MEM_SUM <= 23'h0;
      MEM_COUNT <= 16'h0;
    end else begin
      BLOCK_EST_VALID <= blk_done;
      if (NB_VALID) begin
        if (blk_done) begin
          pix_cnt_reg <= 7'h00;
          blk_min_reg <= `NEMM_EST_NONE;
          BLOCK_EST <= blk_cand;
        end else begin
          pix_cnt_reg <= pix_cnt_reg + 7'h01;
          blk_min_reg <= blk_cand;
        end
      end
      MEM_WR <= FRAME_END;
      if (FRAME_END) begin
        MEM_STREAM <= stream_select;
        MEM_SUM <= acc_reg[stream_select];
        MEM_COUNT <= cnt_reg[stream_select];
      end
    end
  end

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_stream
      wire hit = (stream_select == s);
      wire add = blk_add && hit;
      always @(posedge CLK) begin
        if (!RST_N) begin
          acc_reg[s] <= 23'h0;
          cnt_reg[s] <= 16'h0;
        end else if (FRAME_END && hit) begin
          // Totals leave this cycle; a block closing now opens the new frame
          acc_reg[s] <= add ? {15'h0, blk_cand} : 23'h0;
          cnt_reg[s] <= add ? 16'h0001 : 16'h0;
        end else if (add) begin
          acc_reg[s] <= acc_reg[s] + {15'h0, blk_cand};
          cnt_reg[s] <= cnt_reg[s] + 16'h0001;
        end
      end
    end
  endgenerate

  // ===================================================================
  // Motion measure for one pixel pair
  reg [7:0] wc [0:`NEMM_WN-1];
  reg [7:0] wf [0:`NEMM_WN-1];
  reg [7:0] wr [0:`NEMM_WN-1];
  integer fx, fy, w, p, row, cf, rf, d, tdm, vecm, scm, den, num, q, k;
  integer vertical_complexity, horizontal_complexity;
  reg [2:0] qsh;
  reg [3:0] rsh;
  reg [7:0] motion_new, smoothed_motion;

  always @* begin
    for (p = 0; p < `NEMM_WN; p = p + 1) begin
      row = MM_ROW + p / `NEMM_WW - 4;
      wc[p] = MM_CUR_RAW[p*8 +: 8];
      wr[p] = MM_REF[p*8 +: 8];
      if (noise_filter_on && (top_first ? (row >= `NEMM_NF_TOP_LO && row <= `NEMM_NF_TOP_HI)
                              : (row >= `NEMM_NF_BOT_LO && row <= `NEMM_NF_BOT_HI)))
        wf[p] = MM_CUR_CLEAN[p*8 +: 8];
      else
        wf[p] = wc[p];
    end
    // Even window rows are this field, odd rows the opposite one
    tdm = 0;
    for (fy = 2; fy <= 6; fy = fy + 1) begin
      for (fx = 1; fx <= 4; fx = fx + 1) begin
        w = fy * `NEMM_WW + fx;
        cf = (2 * wf[w] + wf[w-1] + wf[w+1] + 2 * wf[w-12] + 2 * wf[w+12])
             >> `NEMM_FILT_SH;
        rf = (2 * wr[w] + wr[w-1] + wr[w+1] + 2 * wr[w-12] + 2 * wr[w+12])
             >> `NEMM_FILT_SH;
        d = cf - rf;
        tdm = tdm + ((d < 0) ? -d : d);
      end
    end
    vertical_complexity = 0;
    horizontal_complexity = 0;
    vecm = 0;
    for (fy = 2; fy <= 6; fy = fy + 1) begin
      for (fx = 1; fx <= 3; fx = fx + 1) begin
        w = fy * `NEMM_WW + fx;
        d = wc[w] - wc[w+1];
        if (d < 0) d = -d;
        if (fy >= 3 && fy <= 5) horizontal_complexity = horizontal_complexity + d;
        if (fx == 2) vecm = vecm + d;
        d = wc[w] - wc[w-12];
        if (d < 0) d = -d;
        if (fy >= 4 && fx >= 2) vertical_complexity = vertical_complexity + d;
      end
    end
    vecm = (vecm * motion_reg[23:16]) >> `NEMM_VECM_SH;
    scm = vertical_complexity + horizontal_complexity - vecm;
    if (scm < 0) scm = 0;
    den = scm >> `NEMM_SCM_SH;
    if (den < 1) den = 1;
    qsh = motion_reg[2:0];
    if (qsh < `NEMM_QS_MIN) qsh = `NEMM_QS_MIN;
    if (qsh > `NEMM_QS_MAX) qsh = `NEMM_QS_MAX;
    rsh = motion_reg[7:4];
    if (rsh < `NEMM_RS_MIN) rsh = `NEMM_RS_MIN;
    if (rsh > `NEMM_RS_MAX) rsh = `NEMM_RS_MAX;
    num = (tdm >> qsh) << rsh;
    q = num / den + motion_reg[15:8];
    motion_new = (q > 255) ? 8'hFF : q[7:0];
    k = (motion_new > smooth_reg[7:0]) ? smooth_reg[15:8] : smooth_reg[23:16];
    q = (k * MM_SAVED + (`NEMM_WEIGHT_ONE - k) * motion_new) >> `NEMM_AVG_SH;
    smoothed_motion = q[7:0];
  end

  // ===================================================================
  // Smoothed output and horizontal maximum
  reg [7:0] hist1_reg, hist2_reg;
  reg [1:0] fill_reg;
  wire [7:0] max_a = (hist2_reg > hist1_reg) ? hist2_reg : hist1_reg;
  wire [7:0] max_b = (max_a > smoothed_motion) ? max_a : smoothed_motion;

  always @(posedge CLK) begin
    if (!RST_N) begin
      SMOOTH_OUT <= 8'h00;
      SMOOTH_VALID <= 1'b0;
      FINAL_OUT <= 8'h00;
      FINAL_VALID <= 1'b0;
      hist1_reg <= 8'h00;
      hist2_reg <= 8'h00;
      fill_reg <= 2'h0;
      last_final_reg <= 8'h00;
    end else begin
      SMOOTH_VALID <= MM_VALID;
      FINAL_VALID <= MM_VALID && !MM_FIRST && (fill_reg != 2'h0);
      if (MM_VALID) begin
        SMOOTH_OUT <= smoothed_motion;
        hist1_reg <= smoothed_motion;
        if (MM_FIRST) begin
          hist2_reg <= smoothed_motion;
          fill_reg <= 2'h1;
        end else begin
          hist2_reg <= hist1_reg;
          FINAL_OUT <= max_b;
          last_final_reg <= max_b;
        end
      end
    end
  end

endmodule // nemm_top

`default_nettype wire

//--- verif/nemm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module nemm_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Noise estimate
  input wire logic NB_VALID,
  input wire logic FRAME_END,
  input wire logic [7:0] BLOCK_EST,
  input wire logic BLOCK_EST_VALID,
  input wire logic MEM_WR,
  input wire logic [22:0] MEM_SUM,
  input wire logic [15:0] MEM_COUNT,
  // Motion measure
  input wire logic MM_VALID,
  input wire logic MM_FIRST,
  input wire logic REF_IS_NEXT,
  input wire logic [7:0] SMOOTH_OUT,
  input wire logic SMOOTH_VALID,
  input wire logic [7:0] FINAL_OUT,
  input wire logic FINAL_VALID
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ==========
  // Bus answer
  a_bus_answer: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no answer after setup");
  a_bus_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_access: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error outside access");
  // ==========
  // Noise estimate
  a_est_cause: assert property (BLOCK_EST_VALID |-> $past(NB_VALID))
    else $error("estimate without pixel");
  a_est_hold: assert property (!BLOCK_EST_VALID |-> $stable(BLOCK_EST))
    else $error("estimate moved");
  a_total_wr: assert property (FRAME_END |=> MEM_WR)
    else $error("no totals write");
  a_total_sum: assert property (MEM_WR |-> {9'h0, MEM_SUM} <= 254 * MEM_COUNT)
    else $error("sum over count bound");
  // ==========
  // Motion measure
  a_smooth_lat: assert property (SMOOTH_VALID == $past(MM_VALID))
    else $error("smooth latency");
  a_final_first: assert property (MM_VALID && MM_FIRST |=> !FINAL_VALID)
    else $error("final at row start");
  a_final_max: assert property (FINAL_VALID |-> FINAL_OUT >= SMOOTH_OUT
    && FINAL_OUT >= $past(SMOOTH_OUT))
    else $error("final below neighbour");
  a_ref_cause: assert property ($changed(REF_IS_NEXT) |->
    $past(PWRITE && PENABLE, 1) || $past(PWRITE && PENABLE, 2))
    else $error("reference flip without write");
  c_est: cover property (BLOCK_EST_VALID && BLOCK_EST != 8'hFF);
  c_wr: cover property (MEM_WR && MEM_COUNT != 16'h0);
  c_final: cover property (FINAL_VALID);
  c_err: cover property (PSLVERR);
endmodule // nemm_chk
bind nemm_top nemm_chk i_chk (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .NB_VALID(NB_VALID),
  .FRAME_END(FRAME_END), .BLOCK_EST(BLOCK_EST), .BLOCK_EST_VALID(BLOCK_EST_VALID),
  .MEM_WR(MEM_WR), .MEM_SUM(MEM_SUM), .MEM_COUNT(MEM_COUNT), .MM_VALID(MM_VALID),
  .MM_FIRST(MM_FIRST), .REF_IS_NEXT(REF_IS_NEXT), .SMOOTH_OUT(SMOOTH_OUT),
  .SMOOTH_VALID(SMOOTH_VALID), .FINAL_OUT(FINAL_OUT), .FINAL_VALID(FINAL_VALID));
`default_nettype wire

//--- verif/nemm_mem.sv
`timescale 1ns/1ps
`default_nettype none
module nemm_mem (
  // Clock
  input wire logic clk,
  // Frame totals write
  input wire logic wr,
  input wire logic st,
  input wire logic [22:0] sum,
  input wire logic [15:0] cnt,
  // Stored totals per stream, unknown until written
  output logic [22:0] sum_q [2],
  output logic [15:0] cnt_q [2]
);
  always @(posedge clk) begin
    if (wr === 1'b1) begin
      sum_q[st] <= sum;
      cnt_q[st] <= cnt;
    end
  end
endmodule // nemm_mem
`default_nettype wire

//--- verif/noise_estimate_motion_measure_tb.sv
`timescale 1ns/1ps
`default_nettype none
module noise_estimate_motion_measure_tb;
  logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic NB_VALID = 0, FRAME_END = 0, MM_VALID = 0, MM_FIRST = 0;
  logic [7:0] PADDR = 0, MM_SAVED = 0;
  logic [31:0] PWDATA = 0, rd;
  logic [71:0] NB_WIN = 0;
  logic [3:0] MM_ROW = 0;
  logic [431:0] MM_CUR = 0, MM_DN = 0, MM_REF = 0;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, BLOCK_EST_VALID, MEM_WR, MEM_STREAM;
  wire REF_IS_NEXT, SMOOTH_VALID, FINAL_VALID;
  wire [7:0] BLOCK_EST, SMOOTH_OUT, FINAL_OUT;
  wire [22:0] MEM_SUM;
  wire [15:0] MEM_COUNT;
  logic [22:0] tot_s [2];
  logic [15:0] tot_c [2];
  logic [7:0] exs [$], exf [$];
  logic er;
  int n_fail = 0, cmp_count = 0, n_est = 0, es = 0, ec = 0;
  int k, qs = 4, rs = 6, off = 0, vm = 16;
  nemm_top i_dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .NB_VALID(NB_VALID), .NB_WIN(NB_WIN), .FRAME_END(FRAME_END),
    .BLOCK_EST(BLOCK_EST), .BLOCK_EST_VALID(BLOCK_EST_VALID), .MEM_WR(MEM_WR),
    .MEM_STREAM(MEM_STREAM), .MEM_SUM(MEM_SUM), .MEM_COUNT(MEM_COUNT),
    .MM_VALID(MM_VALID), .MM_FIRST(MM_FIRST), .MM_ROW(MM_ROW), .MM_CUR_RAW(MM_CUR),
    .MM_CUR_CLEAN(MM_DN), .MM_REF(MM_REF), .MM_SAVED(MM_SAVED), .REF_IS_NEXT(REF_IS_NEXT),
    .SMOOTH_OUT(SMOOTH_OUT), .SMOOTH_VALID(SMOOTH_VALID), .FINAL_OUT(FINAL_OUT),
    .FINAL_VALID(FINAL_VALID));
  nemm_mem i_mem (.clk(CLK), .wr(MEM_WR), .st(MEM_STREAM), .sum(MEM_SUM),
    .cnt(MEM_COUNT), .sum_q(tot_s), .cnt_q(tot_c));
  initial forever #2.5 CLK = ~CLK;
  // ==========
  // Checking helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Current is a ramp, a per column and b per line; flat reference lv; clean rows equal lv
  function automatic logic [7:0] sm(input logic [7:0] s, input int lv, a, b, dn);
    int raw, w, t, c, v;
    t = 0;
    for (int y = 2; y <= 6; y++) begin
      for (int x = 1; x <= 4; x++) begin
        v = a * x + b * y - lv;
        t += dn ? 0 : (v < 0 ? -v : v);
      end
    end
    c = 12 * b + 9 * a - ((5 * a * vm) >> 5);
    c = c < 0 ? 0 : c >> 4;
    if (c < 1) c = 1;
    raw = (((t >> qs) << rs) / c) + off;
    if (raw > 255) raw = 255;
    w = raw > 32 ? 64 : 200;
    return (w * s + (256 - w) * raw) >> 8;
  endfunction
  // ==========
  // Bus and stream drivers
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    k = 0;
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 9);
    if (k == 9) n_fail++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  // Mode 0 and 8: flat window with centre offset; mode 16: bottom row raised by 4
  task nblk(input int n, input int base, input logic [7:0] m);
    logic [7:0] v, d;
    for (int i = 0; i < n; i++) begin
      v = 8'h10 + $urandom % 8'hC0;
      d = base + $urandom % 8;
      if (base == 0 && d < m) m = d;
      @(posedge CLK);
      NB_VALID <= 1;
      NB_WIN <= base == 16 ? {{3{v + 8'h4}}, {6{v}}} : {{4{v}}, v + d, {4{v}}};
    end
    @(posedge CLK);
    NB_VALID <= 0;
    @(posedge CLK);
    #1 chk(BLOCK_EST, m);
    if (m != 8'hFF) es += m;
    if (m != 8'hFF) ec++;
  endtask
  task fend(input int s);
    @(posedge CLK);
    FRAME_END <= 1;
    @(posedge CLK);
    FRAME_END <= 0;
    repeat (2) @(posedge CLK);
    chk(tot_s[s], es);
    chk(tot_c[s], ec);
    es = 0;
    ec = 0;
  endtask
  // Top field first: row 2 takes every line clean, rows 11 and up none
  task mrow(input int n);
    logic [7:0] sv [8], e [8], m;
    int lv [8], a [8], b [8], r [8];
    logic [431:0] win;
    for (int i = 0; i < n; i++) begin
      sv[i] = $urandom;
      lv[i] = $urandom % 8;
      a[i] = $urandom % 16;
      b[i] = $urandom % 16;
      r[i] = $urandom % 2 ? 2 : 11 + $urandom % 5;
      e[i] = sm(sv[i], lv[i], a[i], b[i], r[i] == 2);
      exs.push_back(e[i]);
    end
    for (int i = 0; i + 1 < n; i++) begin
      m = e[i + 1] > e[i] ? e[i + 1] : e[i];
      if (i > 0 && e[i - 1] > m) m = e[i - 1];
      exf.push_back(m);
    end
    for (int i = 0; i < n; i++) begin
      for (int p = 0; p < 54; p++) begin
        win[p * 8 +: 8] = a[i] * (p % 6) + b[i] * (p / 6);
      end
      @(posedge CLK);
      MM_VALID <= 1;
      MM_FIRST <= i == 0;
      MM_ROW <= r[i];
      MM_CUR <= win;
      MM_DN <= {54{lv[i][7:0]}};
      MM_REF <= {54{lv[i][7:0]}};
      MM_SAVED <= sv[i];
    end
    @(posedge CLK);
    MM_VALID <= 0;
    repeat (2) @(posedge CLK);
  endtask
  always @(posedge CLK) begin
    if (BLOCK_EST_VALID === 1'b1) n_est++;
    if (SMOOTH_VALID === 1'b1) chk(SMOOTH_OUT, exs.size() ? exs.pop_front() : 9'h100);
    if (FINAL_VALID === 1'b1) chk(FINAL_OUT, exf.size() ? exf.pop_front() : 9'h100);
  end
  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    summarize;
  end
  // ==========
  // Main sequence
  initial begin
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h24};
    logic [31:0] rv [5] = '{32'h13, 32'h808, 32'h100064, 32'hC84020, 32'h0};
    void'($urandom(32'hD962));
    repeat (12) @(posedge CLK);
    RST_N <= 1;
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      chk(rd, rv[i]);
    end
    chk(er, 1);
    apb(1, 8'h10, 32'h55);
    apb(0, 8'h10, 0);
    chk(rd, 0);
    $display("test registers done");
    nblk(64, 0, 8'hFF);
    nblk(64, 8, 8'hFF);
    apb(1, 8'h04, 32'h0803);
    nblk(64, 16, 8'h0C);
    apb(1, 8'h04, 32'h0802);
    nblk(64, 16, 8'hFF);
    chk(n_est, 4);
    fend(0);
    apb(1, 8'h04, 32'h0808);
    apb(1, 8'h00, 32'h17);
    nblk(64, 0, 8'hFF);
    nblk(64, 0, 8'hFF);
    fend(1);
    fend(1);
    apb(1, 8'h00, 32'h16);
    k = n_est;
    nblk(128, 0, 8'hFF);
    chk(n_est - k, 1);
    fend(1);
    $display("test noise estimate done");
    apb(1, 8'h00, 32'h1B);
    repeat (3) @(posedge CLK);
    chk(REF_IS_NEXT, 1);
    mrow(5);
    mrow(2);
    apb(1, 8'h08, 32'h100A75);
    qs = 5;
    rs = 7;
    off = 10;
    mrow(4);
    apb(1, 8'h08, 32'h100007);
    qs = 6;
    rs = 6;
    off = 0;
    mrow(6);
    apb(1, 8'h08, 32'h1000F3);
    qs = 4;
    rs = 8;
    mrow(3);
    chk(exs.size() + exf.size(), 0);
    $display("test motion done");
    summarize;
  end
endmodule // noise_estimate_motion_measure_tb
`default_nettype wire
